// ### design/fcs_map.vh
// Constants for the fieldbus master cycle scheduler
`ifndef FCS_MAP_VH
`define FCS_MAP_VH

// Core clock rate
`define FCS_CLK_MHZ 8'h14
// Bus timing in bit times
`define FCS_T_SLOT_BITS 8'h64
`define FCS_T_SYN_BITS 8'h21
`define FCS_T_IDLE_BITS 8'h25
// Shortest bus cycle, microseconds
`define FCS_MIN_CYCLE_US 16'h03E8
// Host refresh duration terms, microseconds
`define FCS_RF_BASE_US 16'h03E8
`define FCS_RF_AREA_US 16'h0190
`define FCS_RF_WORD_US 16'h0012
// Frame formats
`define FCS_FMT_FIXED0 2'h0
`define FCS_FMT_FIXED8 2'h1
`define FCS_FMT_VAR 2'h2
`define FCS_FIXED_LEN 8'h08
// Message kinds
`define FCS_KIND_DATA 2'h0
`define FCS_KIND_LOW 2'h1
`define FCS_KIND_POLL 2'h2

`endif

// ### design/fcs_bit_timer.v
// Bit-time tick generator and bit-time interval timer
`timescale 1ns/1ps
module fcs_bit_timer #(
	parameter DIV_W = 16,
	parameter CNT_W = 8
) (
	input wire core_clk_i,
	input wire sys_rst_i,
	input wire [DIV_W-1:0] bit_div_i,
	input wire load_i,
	input wire [CNT_W-1:0] bits_i,
	output reg bit_tick_o,
	output reg done_o
);
	reg [DIV_W-1:0] div_reg;
	reg [CNT_W-1:0] cnt_reg;
	reg run_reg;
	wire [DIV_W-1:0] div_last;

	// A divisor of zero would stall the tick, so treat it as one
	assign div_last = (bit_div_i == {DIV_W{1'b0}}) ? {DIV_W{1'b0}} :
		bit_div_i - {{(DIV_W-1){1'b0}}, 1'b1};

	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			div_reg <= {DIV_W{1'b0}};
			bit_tick_o <= 1'b0;
		end else if (div_reg >= div_last) begin
			div_reg <= {DIV_W{1'b0}};
			bit_tick_o <= 1'b1;
		end else begin
			div_reg <= div_reg + {{(DIV_W-1){1'b0}}, 1'b1};
			bit_tick_o <= 1'b0;
		end
	end

	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			cnt_reg <= {CNT_W{1'b0}};
			run_reg <= 1'b0;
			done_o <= 1'b0;
		end else if (load_i) begin
			cnt_reg <= bits_i;
			run_reg <= 1'b1;
			done_o <= 1'b0;
		end else if (run_reg && bit_tick_o) begin
			if (cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
				run_reg <= 1'b0;
				done_o <= 1'b1;
			end else begin
				done_o <= 1'b0;
			end
			cnt_reg <= cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
		end else begin
			done_o <= 1'b0;
		end
	end
endmodule

// ### design/fcs_scheduler.v
// Fieldbus master bus-cycle scheduler and host refresh policy
`timescale 1ns/1ps
`include "fcs_map.vh"
module fcs_scheduler #(
	parameter [23:0] MIN_CYC = {8'h00, `FCS_MIN_CYCLE_US * `FCS_CLK_MHZ},
	parameter [23:0] RF_BASE_CYC = {8'h00, `FCS_RF_BASE_US * `FCS_CLK_MHZ},
	parameter [23:0] RF_AREA_CYC = {8'h00, `FCS_RF_AREA_US * `FCS_CLK_MHZ},
	parameter [23:0] RF_WORD_CYC = {8'h00, `FCS_RF_WORD_US * `FCS_CLK_MHZ}
) (
	input wire core_clk_i,
	input wire sys_rst_i,
	input wire [15:0] bit_div_i,
	input wire [6:0] own_addr_i,
	input wire [6:0] highest_station_address_i,
	input wire next_master_valid_i,
	input wire [6:0] next_master_addr_i,
	input wire [7:0] slot_bits_i,
	input wire [15:0] target_rot_bits_i,
	input wire sync_mode_i,
	input wire init_done_i,
	input wire download_i,
	input wire comm_inhibit_i,
	input wire [6:0] num_slaves_i,
	input wire [7:0] msg_len_i,
	input wire low_pending_i,
	input wire tx_done_i,
	input wire rx_reply_i,
	input wire rx_is_master_i,
	input wire refresh_start_i,
	input wire [2:0] map_areas_i,
	input wire [8:0] map_words_i,
	output reg tx_start_o,
	output reg [1:0] tx_kind_o,
	output reg [1:0] tx_fmt_o,
	output reg [6:0] tx_index_o,
	output reg [6:0] tx_addr_o,
	output reg cycle_busy_o,
	output reg cycle_done_o,
	output reg [127:0] active_station_list_o,
	output reg refresh_busy_o,
	output reg host_control_status_words_xfer_o,
	output reg input_xfer_o,
	output reg output_xfer_o,
	output reg status_xfer_o
);
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_GAP = 6'h02;
	localparam [5:0] ST_SEND = 6'h04;
	localparam [5:0] ST_WAIT = 6'h08;
	localparam [5:0] ST_NEXT = 6'h10;
	localparam [5:0] ST_HOLD = 6'h20;
	localparam [7:0] GAP_BITS = (`FCS_T_IDLE_BITS > `FCS_T_SYN_BITS) ?
		`FCS_T_IDLE_BITS : `FCS_T_SYN_BITS;

	reg [5:0] state_reg;
	reg [6:0] msg_reg;
	reg [6:0] poll_reg;
	reg [127:0] mst_reg;
	reg low_sent_reg;
	reg low_ok_reg;
	reg [23:0] cyc_clk_reg;
	reg [15:0] cyc_bits_reg;
	reg [6:0] guard_reg;
	reg new_in_reg;
	reg trig_reg;
	reg withhold_reg;
	reg [23:0] rf_reg;
	reg tmr_load;
	reg [7:0] tmr_bits;
	wire bit_tick;
	wire tmr_done;
	wire sel_data;
	wire sel_low;
	wire cyc_start;
	wire cyc_end;
	wire rf_end;
	wire [6:0] next_addr;
	wire [6:0] step_addr;
	wire [2:0] na_eff;
	wire [23:0] rf_len;

	fcs_bit_timer #(.DIV_W(16), .CNT_W(8)) u_timer (
		.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i),
		.bit_div_i(bit_div_i),
		.load_i(tmr_load),
		.bits_i(tmr_bits),
		.bit_tick_o(bit_tick),
		.done_o(tmr_done)
	);

	assign sel_data = msg_reg < num_slaves_i;
	assign sel_low = !sel_data && low_pending_i && low_ok_reg &&
		!low_sent_reg;
	assign cyc_start = (state_reg == ST_IDLE) && init_done_i &&
		!comm_inhibit_i && (!sync_mode_i || trig_reg);
	assign cyc_end = (state_reg == ST_HOLD) && (cyc_clk_reg >= MIN_CYC);
	assign rf_end = refresh_busy_o && (rf_reg <= 24'h000001);

	// Range ends at the next master, or wraps past the highest address
	assign step_addr = poll_reg + 7'h01;
	assign next_addr =
		(next_master_valid_i && step_addr >= next_master_addr_i &&
			poll_reg < next_master_addr_i) ? own_addr_i + 7'h01 :
		(!next_master_valid_i && poll_reg >= highest_station_address_i) ?
			7'h00 :
		(step_addr == own_addr_i) ? own_addr_i + 7'h01 : step_addr;

	always @* begin
		tmr_load = 1'b0;
		tmr_bits = GAP_BITS;
		case (state_reg)
			ST_IDLE: begin
				tmr_load = cyc_start;
			end
			ST_SEND: begin
				tmr_load = tx_done_i;
				tmr_bits = (slot_bits_i == 8'h00) ? `FCS_T_SLOT_BITS :
					slot_bits_i;
			end
			ST_WAIT: begin
				tmr_load = (rx_reply_i || tmr_done) && tx_kind_o !=
					`FCS_KIND_POLL;
			end
			default: begin
				tmr_load = 1'b0;
			end
		endcase
	end

	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			state_reg <= ST_IDLE;
			msg_reg <= 7'h00;
			poll_reg <= 7'h00;
			mst_reg <= {128{1'b0}};
			active_station_list_o <= {128{1'b0}};
			low_sent_reg <= 1'b0;
			low_ok_reg <= 1'b1;
			cyc_clk_reg <= 24'h000000;
			cyc_bits_reg <= 16'h0000;
			guard_reg <= 7'h00;
			tx_start_o <= 1'b0;
			tx_kind_o <= `FCS_KIND_DATA;
			tx_fmt_o <= `FCS_FMT_FIXED0;
			tx_index_o <= 7'h00;
			tx_addr_o <= 7'h00;
			cycle_busy_o <= 1'b0;
			cycle_done_o <= 1'b0;
		end else begin
			tx_start_o <= 1'b0;
			cycle_done_o <= 1'b0;
			if (cycle_busy_o) begin
				if (cyc_clk_reg != 24'hFFFFFF)
					cyc_clk_reg <= cyc_clk_reg + 24'h000001;
				if (bit_tick && cyc_bits_reg != 16'hFFFF)
					cyc_bits_reg <= cyc_bits_reg + 16'h0001;
			end
			case (state_reg)
				ST_IDLE: begin
					if (cyc_start) begin
						msg_reg <= 7'h00;
						low_sent_reg <= 1'b0;
						cyc_clk_reg <= 24'h000000;
						cyc_bits_reg <= 16'h0000;
						cycle_busy_o <= 1'b1;
						state_reg <= ST_GAP;
					end
				end
				ST_GAP: begin
					if (tmr_done) begin
						tx_start_o <= 1'b1;
						state_reg <= ST_SEND;
						if (sel_data || sel_low) begin
							tx_kind_o <= sel_data ? `FCS_KIND_DATA :
								`FCS_KIND_LOW;
							tx_index_o <= msg_reg;
							tx_fmt_o <= (msg_len_i == 8'h00) ?
								`FCS_FMT_FIXED0 :
								(msg_len_i == `FCS_FIXED_LEN) ?
								`FCS_FMT_FIXED8 : `FCS_FMT_VAR;
							low_sent_reg <= low_sent_reg | sel_low;
						end else begin
							tx_kind_o <= `FCS_KIND_POLL;
							tx_addr_o <= poll_reg;
							tx_fmt_o <= `FCS_FMT_FIXED0;
						end
					end
				end
				ST_SEND: begin
					if (tx_done_i)
						state_reg <= ST_WAIT;
				end
				ST_WAIT: begin
					// One reply or the slot timeout closes the message
					if (rx_reply_i || tmr_done) begin
						if (tx_kind_o == `FCS_KIND_POLL) begin
							active_station_list_o[poll_reg] <= rx_reply_i;
							mst_reg[poll_reg] <= rx_reply_i && rx_is_master_i;
							guard_reg <= 7'h00;
							state_reg <= ST_NEXT;
						end else begin
							if (tx_kind_o == `FCS_KIND_DATA)
								msg_reg <= msg_reg + 7'h01;
							state_reg <= ST_GAP;
						end
					end
				end
				ST_NEXT: begin
					poll_reg <= next_addr;
					guard_reg <= guard_reg + 7'h01;
					// Guard stops the search if every station is a master
					if (!(active_station_list_o[next_addr] &&
						mst_reg[next_addr]) || guard_reg == 7'h7F)
						state_reg <= ST_HOLD;
				end
				ST_HOLD: begin
					if (cyc_end) begin
						low_ok_reg <= cyc_bits_reg < target_rot_bits_i;
						cycle_busy_o <= 1'b0;
						cycle_done_o <= 1'b1;
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	assign na_eff = (map_areas_i == 3'h0) ? 3'h1 : map_areas_i;
	assign rf_len = RF_BASE_CYC + {21'h000000, na_eff} * RF_AREA_CYC +
		{15'h0000, map_words_i} * RF_WORD_CYC;

	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			rf_reg <= 24'h000000;
			refresh_busy_o <= 1'b0;
			host_control_status_words_xfer_o <= 1'b0;
			input_xfer_o <= 1'b0;
			output_xfer_o <= 1'b0;
			status_xfer_o <= 1'b0;
			new_in_reg <= 1'b0;
			trig_reg <= 1'b0;
			withhold_reg <= 1'b0;
		end else begin
			host_control_status_words_xfer_o <= 1'b0;
			input_xfer_o <= 1'b0;
			output_xfer_o <= 1'b0;
			status_xfer_o <= 1'b0;
			if (refresh_start_i && !refresh_busy_o) begin
				refresh_busy_o <= 1'b1;
				rf_reg <= rf_len;
				host_control_status_words_xfer_o <= 1'b1;
				input_xfer_o <= new_in_reg && !comm_inhibit_i;
				output_xfer_o <= init_done_i && !download_i &&
					!(sync_mode_i && cycle_busy_o);
				status_xfer_o <= init_done_i;
				if (sync_mode_i && cycle_busy_o)
					withhold_reg <= 1'b1;
			end else if (rf_end) begin
				refresh_busy_o <= 1'b0;
				rf_reg <= 24'h000000;
				withhold_reg <= 1'b0;
			end else if (refresh_busy_o) begin
				rf_reg <= rf_reg - 24'h000001;
			end
			// A finishing cycle beats a same-cycle take
			new_in_reg <= cycle_done_o || (new_in_reg &&
				!(refresh_start_i && !refresh_busy_o && !comm_inhibit_i));
			if (rf_end && sync_mode_i && !withhold_reg)
				trig_reg <= 1'b1;
			else if (cyc_start || !sync_mode_i)
				trig_reg <= 1'b0;
		end
	end
endmodule

// ### tb/fcs_scheduler_sva.sv
// Port assertions for the bus-cycle scheduler
`timescale 1ns/1ps
module fcs_scheduler_sva #(
	parameter [23:0] MIN_CYC = 24'h004E20
) (
	input wire core_clk_i,
	input wire sys_rst_i,
	input wire sync_mode_i,
	input wire init_done_i,
	input wire download_i,
	input wire comm_inhibit_i,
	input wire refresh_start_i,
	input wire tx_start_o,
	input wire [1:0] tx_fmt_o,
	input wire cycle_busy_o,
	input wire cycle_done_o,
	input wire refresh_busy_o,
	input wire host_control_status_words_xfer_o,
	input wire input_xfer_o,
	input wire output_xfer_o,
	input wire status_xfer_o
);
	reg [23:0] run_reg = 24'h000000;
	// Counts busy cycles; cleared while idle so each cycle is timed afresh
	always @(posedge core_clk_i)
		run_reg <= (sys_rst_i || !cycle_busy_o) ? 24'h000000 :
			run_reg + 24'h000001;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_take;
		refresh_start_i && !refresh_busy_o;
	endsequence
	property p_gap;
		tx_start_o |=> !tx_start_o [*8];
	endproperty
	a_gap: assert property (p_gap) else $error("frames too close");
	property p_fmt;
		tx_start_o |-> tx_fmt_o != 2'h3;
	endproperty
	a_fmt: assert property (p_fmt) else $error("bad format");
	property p_ctl;
		s_take |=> host_control_status_words_xfer_o && refresh_busy_o;
	endproperty
	a_ctl: assert property (p_ctl) else $error("no control words");
	property p_stat;
		s_take ##0 init_done_i |=> status_xfer_o;
	endproperty
	a_stat: assert property (p_stat) else $error("no status");
	property p_inh;
		s_take ##0 comm_inhibit_i |=> !input_xfer_o;
	endproperty
	a_inh: assert property (p_inh) else $error("input while inhibited");
	property p_dl;
		s_take ##0 download_i |=> !output_xfer_o;
	endproperty
	a_dl: assert property (p_dl) else $error("output in download");
	property p_sout;
		s_take ##0 (sync_mode_i && cycle_busy_o) |=> !output_xfer_o;
	endproperty
	a_sout: assert property (p_sout) else $error("late output");
	property p_min;
		cycle_done_o |-> run_reg >= MIN_CYC - 24'h000002;
	endproperty
	a_min: assert property (p_min) else $error("cycle too short");
	property p_async;
		cycle_done_o && !sync_mode_i && init_done_i && !comm_inhibit_i
			|-> ##[1:3] cycle_busy_o;
	endproperty
	a_async: assert property (p_async) else $error("no restart");
endmodule
bind fcs_scheduler fcs_scheduler_sva #(.MIN_CYC(MIN_CYC)) u_sva (
	.core_clk_i, .sys_rst_i, .sync_mode_i, .init_done_i, .download_i,
	.comm_inhibit_i, .refresh_start_i, .tx_start_o, .tx_fmt_o,
	.cycle_busy_o, .cycle_done_o, .refresh_busy_o,
	.host_control_status_words_xfer_o, .input_xfer_o, .output_xfer_o,
	.status_xfer_o);

// ### tb/fcs_bus_model.sv
// Far-side stations: one reply per action frame after a set delay, except polls of stations absent from present_i
`timescale 1ns/1ps
module fcs_bus_model #(
	parameter [6:0] MST = 7'h05
) (
	input wire core_clk_i,
	input wire sys_rst_i,
	input wire start_i,
	input wire [1:0] kind_i,
	input wire [6:0] addr_i,
	input wire [127:0] present_i,
	input wire [3:0] delay_i,
	output reg done_o = 1'b0,
	output reg reply_o = 1'b0,
	output reg master_o = 1'b0
);
	reg [3:0] cnt_reg = 4'h0;
	reg [1:0] ph_reg = 2'h0;
	reg ans_reg = 1'b0;
	reg mst_reg = 1'b0;
	always @(posedge core_clk_i) begin
		done_o <= 1'b0;
		reply_o <= 1'b0;
		// Qualifier is meaningless without a reply, so it wanders
		master_o <= ~master_o;
		if (sys_rst_i)
			ph_reg <= 2'h0;
		else if (start_i) begin
			ph_reg <= 2'h1;
			cnt_reg <= delay_i;
			ans_reg <= kind_i != 2'h2 || present_i[addr_i];
			mst_reg <= addr_i == MST;
		end else if (ph_reg != 2'h0 && cnt_reg != 4'h0)
			cnt_reg <= cnt_reg - 4'h1;
		else if (ph_reg == 2'h1) begin
			done_o <= 1'b1;
			ph_reg <= 2'h2;
			cnt_reg <= delay_i;
		end else if (ph_reg == 2'h2) begin
			reply_o <= ans_reg;
			master_o <= mst_reg;
			ph_reg <= 2'h0;
		end
	end
endmodule

// ### tb/tb_fcs_scheduler.sv
// Bench: refresh driver, station model and output watcher
`timescale 1ns/1ps
module tb_fcs_scheduler;
	reg core_clk_i = 1'b0;
	reg sys_rst_i = 1'b1;
	reg sync = 1'b0, inh = 1'b0, dl = 1'b0, rs = 1'b0, sil = 1'b0, wb = 1'b0;
	reg [15:0] trot = 16'hFFFF;
	reg [15:0] l;
	reg [2:0] na = 3'h0;
	reg [8:0] nw = 9'h000;
	reg [7:0] len = 8'h00;
	reg [3:0] dly = 4'h1;
	reg [15:0] div = 16'h0001;
	reg [6:0] own = 7'h03, highest_station_address = 7'h06, nma = 7'h00, nsl = 7'h02;
	reg nmv = 1'b0, ini = 1'b1, lowp = 1'b1;
	reg [7:0] slot = 8'h00;
	reg [127:0] pres = 128'h32;
	reg [16:0] lf = 17'h153EF;
	reg [19:0] e;
	reg [19:0] q[$];
	wire dn, rp, rm, ts, cb, cd, rb, xc, xi, xo, xs;
	wire [1:0] kd, fm;
	wire [6:0] ix, ad;
	wire [127:0] asl;
	integer mismatches = 0, comparisons = 0, dones = 0, last = 0, i, k;
	integer np = 0, npc = 0, nl = 0, di = 0, sc = 0, sl = 0, lx = 1, lk = 0;
	integer st = 100;
	always #25 core_clk_i = ~core_clk_i;
	fcs_scheduler #(.MIN_CYC(24'h000014), .RF_BASE_CYC(24'h00000A),
		.RF_AREA_CYC(24'h000004), .RF_WORD_CYC(24'h000001)) uut (
		.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .bit_div_i(div),
		.own_addr_i(own), .highest_station_address_i(highest_station_address),
		.next_master_valid_i(nmv), .next_master_addr_i(nma),
		.slot_bits_i(slot), .target_rot_bits_i(trot), .sync_mode_i(sync),
		.init_done_i(ini), .download_i(dl), .comm_inhibit_i(inh),
		.num_slaves_i(nsl), .msg_len_i(len), .low_pending_i(lowp),
		.tx_done_i(dn), .rx_reply_i(rp), .rx_is_master_i(rm),
		.refresh_start_i(rs), .map_areas_i(na), .map_words_i(nw),
		.tx_start_o(ts), .tx_kind_o(kd), .tx_fmt_o(fm), .tx_index_o(ix),
		.tx_addr_o(ad), .cycle_busy_o(cb), .cycle_done_o(cd),
		.active_station_list_o(asl), .refresh_busy_o(rb),
		.host_control_status_words_xfer_o(xc), .input_xfer_o(xi),
		.output_xfer_o(xo), .status_xfer_o(xs));
	fcs_bus_model stn (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.start_i(ts), .kind_i(kd), .addr_i(ad), .present_i(pres),
		.delay_i(dly), .done_o(dn), .reply_o(rp), .master_o(rm));
	function [16:0] lfsr(input [16:0] v);
		lfsr = {v[15:0], v[16] ^ v[13]};
	endfunction
	task chk(input ok, input string m);
		comparisons = comparisons + 1;
		if (!ok) begin
			mismatches = mismatches + 1;
			$display("Error at %0t: %s", $time, m);
		end
	endtask
	task test_done;
		if (mismatches == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task wt(input [1:0] s, input integer n);
		integer j;
		reg h;
		begin
			h = 1'b0;
			for (j = 0; j < n && !h; j = j + 1) begin
				@(posedge core_clk_i);
				#1;
				h = s == 0 ? cb === 1'b1 : s == 1 ? cb === 1'b0 :
					s == 2 ? rb === 1'b0 : ts === 1'b1;
			end
			if (!h) begin
				chk(1'b0, "wait ran out");
				test_done;
			end
		end
	endtask
	// Expectation is formed before the take edge so a cycle end seen there
	// is left for the next take; an inhibited take leaves new input pending
	task rf(input ex_o);
		@(posedge core_clk_i);
		l = 16'h000A + {10'h000, lf[13:8]} +
			16'h0004 * (lf[7:5] == 3'h0 ? 16'h0001 : {13'h0000, lf[7:5]});
		na <= lf[7:5];
		nw <= {3'h0, lf[13:8]};
		rs <= 1'b1;
		#1;
		q.push_back({1'b1, dones != last && !inh, ex_o, 1'b1, l});
		if (!inh)
			last = dones;
		@(posedge core_clk_i);
		rs <= 1'b0;
		wt(2, 9000);
	endtask
	always @(posedge core_clk_i) begin
		if (rb === 1'b1 && !wb) begin
			e = q.pop_front();
			sc = 1;
			chk({xc, xi, xo, xs} === e[19:16], "refresh transfers");
		end else if (rb === 1'b1)
			sc = sc + 1;
		else if (wb)
			chk(sc === e[15:0], "refresh length");
		wb = rb;
		sl = sl + 1;
		if (dn === 1'b1) begin
			lf = lfsr(lf);
			dly <= lf[3:0] | 4'h1;
			len <= lf[4] ? {4'h0, lf[8:5]} : {4'h0, lf[5], 3'h0};
			sl = 0;
		end
		if (ts === 1'b1 && kd === 2'h2) begin
			k = np < 6 ? np : (np - 6) % 5;
			chk(ad === (k < 3 ? k : np < 6 ? k + 1 : k * 2 - 2), "poll");
			sil = !pres[ad];
			np = np + 1;
			npc = npc + 1;
		end else if (ts === 1'b1 && kd === 2'h1)
			nl = nl + 1;
		else if (ts === 1'b1) begin
			chk(ix === di && fm === (len == 0 ? 0 : len == 8 ? 1 : 2), "data");
			di = di + 1;
		end
		if (cd === 1'b1) begin
			if (sil)
				chk(sl >= st && sl <= st + 6, "slot time");
			if (lk > 0)
				lk = lk - 1;
			else
				chk(nl === lx, "low priority");
			chk(npc === 1 && di === 2, "cycle content");
			sil = 1'b0;
			nl = 0;
			di = 0;
			npc = 0;
			dones = dones + 1;
		end
	end
	initial begin
		repeat (12) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		for (i = 0; i < 3; i = i + 1) begin
			wt(1, 9000);
			wt(3, 9000);
			dl <= i == 1;
			inh <= i == 2;
			rf(i != 1);
			inh <= 1'b0;
			dl <= 1'b0;
		end
		repeat (7) wt(3, 9000);
		repeat (7) begin
			wt(1, 9000);
			wt(0, 9000);
		end
		chk(asl[6:0] === 7'h32, "live list");
		trot <= 16'h0001;
		slot <= 8'h50;
		st = 80;
		lk = 2;
		lx = 0;
		pres[4] <= 1'b0;
		repeat (7) begin
			wt(1, 9000);
			wt(0, 9000);
		end
		chk(asl[6:0] === 7'h22, "station dropped");
		wt(3, 9000);
		sync <= 1'b1;
		wt(1, 9000);
		repeat (40) @(posedge core_clk_i);
		chk(cb === 1'b0, "sync waits");
		rf(1'b1);
		wt(0, 5);
		rf(1'b0);
		wt(1, 9000);
		repeat (40) @(posedge core_clk_i);
		chk(cb === 1'b0, "withheld");
		rf(1'b1);
		wt(0, 5);
		test_done;
	end
endmodule
